// ===== design/lts_top.sv
// Implementation choices: strobed register access and the placing of the registers.
`default_nettype none
module lts_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // trigger inputs
   input wire logic ext_trig,
   input wire logic bus_trig,
   input wire logic [lts_pkg::ANA_W-1:0] ana_int,
   input wire logic [lts_pkg::ANA_W-1:0] ana_ext,
   // output hardware handshake
   input wire logic action_done,
   output logic action_start,
   // status
   output logic op_pending,
   output logic cmd_error
);
   // ****************************************
   // declarations
   // ****************************************
   lts_pkg::lts_state_e state_q;
   lts_pkg::lts_state_e state_d;
   logic up_q;
   logic up_d;
   logic cont_q;
   logic [2:0] src0_q;
   logic [2:0] src1_q;
   logic [lts_pkg::CNT_W-1:0] cnt0_q;
   logic [lts_pkg::CNT_W-1:0] cnt1_q;
   logic [lts_pkg::CNT_W-1:0] done0_q;
   logic [lts_pkg::CNT_W-1:0] done1_q;
   logic [lts_pkg::CNT_W-1:0] done0_d;
   logic [lts_pkg::CNT_W-1:0] done1_d;
   logic [lts_pkg::ANA_W-1:0] level_q;
   logic [lts_pkg::ANA_W-1:0] hyst_q;
   logic slope_q;
   logic pend_q;
   logic err_q;
   logic start_q;
   logic [15:0] rdata_q;
   logic [15:0] timer_q;
   logic timer_evt;
   logic ext_sync;
   logic ext_prev_q;
   logic ext_rise;
   logic bus_sync;
   logic bus_prev_q;
   logic bus_evt;
   logic evt0;
   logic evt1;
   logic ovr0_q;
   logic ovr1_q;
   logic wr_ctrl;
   logic cmd_init;
   logic cmd_abort;
   logic cmd_reset;
   logic cmd_ovr0;
   logic cmd_ovr1;
   logic cmd_bus;
   logic cmd_clrerr;
   logic force_idle;
   logic bad_ovr;
   logic leave_idle;
   logic go0;
   logic go1;
   logic full0;
   logic full1;
   logic [15:0] status_word;
   logic [15:0] rd_mux;

   // count reached test, a zero count behaves as one
   function automatic logic count_full(input logic [lts_pkg::CNT_W-1:0] done,
                                       input logic [lts_pkg::CNT_W-1:0] limit);
      count_full = (done >= limit);
   endfunction

   // ****************************************
   // command decode
   // ****************************************
   assign wr_ctrl = reg_wr && (reg_addr == lts_pkg::REG_CTRL);
   assign cmd_init = wr_ctrl && reg_wdata[lts_pkg::CTRL_INIT_BIT];
   assign cmd_abort = wr_ctrl && reg_wdata[lts_pkg::CTRL_ABORT_BIT];
   assign cmd_reset = wr_ctrl && reg_wdata[lts_pkg::CTRL_RESET_BIT];
   assign cmd_ovr0 = wr_ctrl && reg_wdata[lts_pkg::CTRL_OVR0_BIT];
   assign cmd_ovr1 = wr_ctrl && reg_wdata[lts_pkg::CTRL_OVR1_BIT];
   assign cmd_bus = wr_ctrl && reg_wdata[lts_pkg::CTRL_BUSTRG_BIT];
   assign cmd_clrerr = wr_ctrl && reg_wdata[lts_pkg::CTRL_CLRERR_BIT];
   assign force_idle = cmd_abort || cmd_reset;
   assign bad_ovr = (cmd_ovr0 && (state_q != lts_pkg::ST_EVT0)) ||
                    (cmd_ovr1 && (state_q != lts_pkg::ST_EVT1));

   // ****************************************
   // event inputs
   // ****************************************
   lts_sync u_ext_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(ext_trig),
      .sync_out(ext_sync)
   );

   lts_sync u_bus_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(bus_trig),
      .sync_out(bus_sync)
   );

   assign ext_rise = ext_sync && !ext_prev_q;
   assign bus_evt = (bus_sync && !bus_prev_q) || cmd_bus;
   assign timer_evt = (timer_q == 16'h0000);

   // edge memory and free-running timer source
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_prev_q <= 1'b0;
         bus_prev_q <= 1'b0;
         timer_q <= lts_pkg::TIMER_PERIOD;
      end else begin
         ext_prev_q <= ext_sync;
         bus_prev_q <= bus_sync;
         timer_q <= timer_evt ? lts_pkg::TIMER_PERIOD : timer_q - 16'h0001;
      end
   end

   lts_qual u_qual0 (
      .clk(clk),
      .rst_n(rst_n),
      .src(src0_q),
      .level(level_q),
      .hyst(hyst_q),
      .slope_fall(slope_q),
      .bus_evt(bus_evt),
      .ext_rise(ext_rise),
      .timer_evt(timer_evt),
      .ana_int(ana_int),
      .ana_ext(ana_ext),
      .evt(evt0)
   );

   lts_qual u_qual1 (
      .clk(clk),
      .rst_n(rst_n),
      .src(src1_q),
      .level(level_q),
      .hyst(hyst_q),
      .slope_fall(slope_q),
      .bus_evt(bus_evt),
      .ext_rise(ext_rise),
      .timer_evt(timer_evt),
      .ana_int(ana_int),
      .ana_ext(ana_ext),
      .evt(evt1)
   );

   // ****************************************
   // sequencer decisions
   // ****************************************
   // initiate from idle
   assign leave_idle = cmd_init || cont_q;
   assign go0 = evt0 || ovr0_q;
   assign go1 = evt1 || ovr1_q;
   assign full0 = count_full(done0_q, cnt0_q);
   assign full1 = count_full(done1_q, cnt1_q);

   // next state, adjacent moves only, except abort or reset straight to idle
   always_comb begin
      state_d = state_q;
      up_d = up_q;
      done0_d = done0_q;
      done1_d = done1_q;
      case (state_q)
         lts_pkg::ST_IDLE: begin
            done0_d = '0;
            done1_d = '0;
            if (leave_idle) begin
               state_d = lts_pkg::ST_INIT;
               up_d = 1'b0;
            end
         end
         lts_pkg::ST_INIT: begin
            if (!up_q) begin
               state_d = lts_pkg::ST_EVT0;
            end else if (cont_q) begin
               state_d = lts_pkg::ST_EVT0;
               up_d = 1'b0;
               done0_d = '0;
            end else begin
               state_d = lts_pkg::ST_IDLE;
            end
         end
         lts_pkg::ST_EVT0: begin
            if (up_q && full0) begin
               state_d = lts_pkg::ST_INIT;
            end else if (go0) begin
               state_d = lts_pkg::ST_EVT1;
               up_d = 1'b0;
               done1_d = '0;
               done0_d = done0_q + 1'b1;
            end
         end
         lts_pkg::ST_EVT1: begin
            if (up_q && full1) begin
               state_d = lts_pkg::ST_EVT0;
            end else if (go1) begin
               state_d = lts_pkg::ST_SEQOP;
               up_d = 1'b0;
               done1_d = done1_q + 1'b1;
            end
         end
         lts_pkg::ST_SEQOP: begin
            if (action_done && !start_q) begin
               state_d = lts_pkg::ST_EVT1;
               up_d = 1'b1;
            end
         end
         default: begin
            state_d = lts_pkg::ST_IDLE;
            up_d = 1'b0;
         end
      endcase
      if (force_idle) begin
         state_d = lts_pkg::ST_IDLE;
         up_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= lts_pkg::ST_IDLE;
         up_q <= 1'b0;
         done0_q <= '0;
         done1_q <= '0;
      end else begin
         state_q <= state_d;
         up_q <= up_d;
         done0_q <= done0_d;
         done1_q <= done1_d;
      end
   end

   // pending flag, action start, override latches and error
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         start_q <= 1'b0;
         ovr0_q <= 1'b0;
         ovr1_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         pend_q <= (state_d != lts_pkg::ST_IDLE);
         start_q <= (state_d == lts_pkg::ST_SEQOP) && (state_q != lts_pkg::ST_SEQOP);
         ovr0_q <= cmd_ovr0 && (state_q == lts_pkg::ST_EVT0) && !force_idle;
         ovr1_q <= cmd_ovr1 && (state_q == lts_pkg::ST_EVT1) && !force_idle;
         // error sticky, set wins over clear
         err_q <= bad_ovr || (err_q && !cmd_clrerr);
      end
   end

   // ****************************************
   // settings registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cont_q <= 1'b0;
         src0_q <= lts_pkg::SRC_IMMEDIATE;
         src1_q <= lts_pkg::SRC_IMMEDIATE;
         cnt0_q <= lts_pkg::CNT_RESET;
         cnt1_q <= lts_pkg::CNT_RESET;
         level_q <= lts_pkg::LEVEL_RESET;
         hyst_q <= lts_pkg::HYST_RESET;
         slope_q <= 1'b0;
      end else if (cmd_reset) begin
         cont_q <= 1'b0;
         src0_q <= lts_pkg::SRC_IMMEDIATE;
         src1_q <= lts_pkg::SRC_IMMEDIATE;
         cnt0_q <= lts_pkg::CNT_RESET;
         cnt1_q <= lts_pkg::CNT_RESET;
         level_q <= lts_pkg::LEVEL_RESET;
         hyst_q <= lts_pkg::HYST_RESET;
         slope_q <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            lts_pkg::REG_CONT: cont_q <= reg_wdata[0];
            lts_pkg::REG_SRC0: src0_q <= reg_wdata[2:0];
            lts_pkg::REG_SRC1: src1_q <= reg_wdata[2:0];
            lts_pkg::REG_CNT0: cnt0_q <= reg_wdata;
            lts_pkg::REG_CNT1: cnt1_q <= reg_wdata;
            lts_pkg::REG_LEVEL: level_q <= reg_wdata[lts_pkg::ANA_W-1:0];
            lts_pkg::REG_HYST: hyst_q <= reg_wdata[lts_pkg::ANA_W-1:0];
            lts_pkg::REG_SLOPE: slope_q <= reg_wdata[0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // read path
   // ****************************************
   assign status_word = {9'h000, start_q || (state_q == lts_pkg::ST_SEQOP), err_q, pend_q, 1'b0, state_q};
   assign rd_mux = (reg_addr == lts_pkg::REG_CONT) ? {15'h0000, cont_q} :
                   (reg_addr == lts_pkg::REG_SRC0) ? {13'h0000, src0_q} :
                   (reg_addr == lts_pkg::REG_SRC1) ? {13'h0000, src1_q} :
                   (reg_addr == lts_pkg::REG_CNT0) ? cnt0_q :
                   (reg_addr == lts_pkg::REG_CNT1) ? cnt1_q :
                   (reg_addr == lts_pkg::REG_LEVEL) ? {4'h0, level_q} :
                   (reg_addr == lts_pkg::REG_HYST) ? {4'h0, hyst_q} :
                   (reg_addr == lts_pkg::REG_SLOPE) ? {15'h0000, slope_q} :
                   (reg_addr == lts_pkg::REG_STATUS) ? status_word : 16'h0000;

   // read data stands for the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign action_start = start_q;
   assign op_pending = pend_q;
   assign cmd_error = err_q;
endmodule // lts_top
`default_nettype wire

// ===== design/lts_pkg.sv
`default_nettype none
package lts_pkg;
   // ****************************************
   // trigger sources
   // ****************************************
   localparam logic [2:0] SRC_IMMEDIATE = 3'h0;
   localparam logic [2:0] SRC_BUS = 3'h1;
   localparam logic [2:0] SRC_EXTERNAL = 3'h2;
   localparam logic [2:0] SRC_TIMER = 3'h3;
   localparam logic [2:0] SRC_ANALOG_INT = 3'h4;
   localparam logic [2:0] SRC_ANALOG_EXT = 3'h5;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0; // write: command pulses
   localparam logic [3:0] REG_CONT = 4'h1; // continuous initiate
   localparam logic [3:0] REG_SRC0 = 4'h2; // layer 0 source
   localparam logic [3:0] REG_SRC1 = 4'h3; // layer 1 source
   localparam logic [3:0] REG_CNT0 = 4'h4; // layer 0 count
   localparam logic [3:0] REG_CNT1 = 4'h5; // layer 1 count
   localparam logic [3:0] REG_LEVEL = 4'h6; // analog level
   localparam logic [3:0] REG_HYST = 4'h7; // analog hysteresis
   localparam logic [3:0] REG_SLOPE = 4'h8; // analog slope, bit 0 = falling
   localparam logic [3:0] REG_STATUS = 4'h9; // read: state and flags

   // ****************************************
   // control register bit positions
   // ****************************************
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int CTRL_RESET_BIT = 2;
   localparam int CTRL_OVR0_BIT = 3;
   localparam int CTRL_OVR1_BIT = 4;
   localparam int CTRL_BUSTRG_BIT = 5;
   localparam int CTRL_CLRERR_BIT = 6;

   // ****************************************
   // status register bit positions
   // ****************************************
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_PEND_BIT = 4;
   localparam int STAT_ERR_BIT = 5;
   localparam int STAT_BUSY_BIT = 6;

   // ****************************************
   // reset values and widths
   // ****************************************
   localparam int CNT_W = 16;
   localparam int ANA_W = 12;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0001;
   localparam logic [ANA_W-1:0] LEVEL_RESET = 12'h800;
   localparam logic [ANA_W-1:0] HYST_RESET = 12'h010;
   localparam logic [15:0] TIMER_PERIOD = 16'h0fa0; // timer reload value, source period is one cycle more

   // ****************************************
   // sequencer states, gray along the path
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_INIT = 3'h1,
      ST_EVT0 = 3'h3,
      ST_EVT1 = 3'h2,
      ST_SEQOP = 3'h6
   } lts_state_e;
endpackage : lts_pkg
`default_nettype wire

// ===== design/lts_sync.sv
`default_nettype none
module lts_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous input and filtered result
   input wire logic async_in,
   output logic sync_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_q;

   // three stages, accept a level once stages two and three agree
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign sync_out = out_q;
endmodule // lts_sync
`default_nettype wire

// ===== design/lts_qual.sv
`default_nettype none
module lts_qual (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // source selection and analog settings
   input wire logic [2:0] src,
   input wire logic [lts_pkg::ANA_W-1:0] level,
   input wire logic [lts_pkg::ANA_W-1:0] hyst,
   input wire logic slope_fall,
   // raw event inputs
   input wire logic bus_evt,
   input wire logic ext_rise,
   input wire logic timer_evt,
   input wire logic [lts_pkg::ANA_W-1:0] ana_int,
   input wire logic [lts_pkg::ANA_W-1:0] ana_ext,
   // qualified event
   output logic evt
);
   logic armed_q;
   logic armed_d;
   logic [lts_pkg::ANA_W-1:0] sample;
   logic [lts_pkg::ANA_W:0] hi_thr;
   logic [lts_pkg::ANA_W:0] lo_thr;
   logic above;
   logic below;
   logic is_analog;
   logic ana_evt;

   // analog sample and hysteresis thresholds
   assign sample = (src == lts_pkg::SRC_ANALOG_EXT) ? ana_ext : ana_int;
   assign hi_thr = {1'b0, level} + {1'b0, hyst};
   assign lo_thr = ({1'b0, level} > {1'b0, hyst}) ? ({1'b0, level} - {1'b0, hyst}) : '0;
   assign above = {1'b0, sample} >= hi_thr;
   assign below = {1'b0, sample} <= lo_thr;
   assign is_analog = (src == lts_pkg::SRC_ANALOG_INT) || (src == lts_pkg::SRC_ANALOG_EXT);

   assign ana_evt = armed_q && (slope_fall ? below : above);
   assign armed_d = slope_fall ? (armed_q ? !below : above) : (armed_q ? !above : below);

   assign evt = (src == lts_pkg::SRC_IMMEDIATE) ? 1'b1 :
                (src == lts_pkg::SRC_BUS) ? bus_evt :
                (src == lts_pkg::SRC_EXTERNAL) ? ext_rise :
                (src == lts_pkg::SRC_TIMER) ? timer_evt :
                is_analog ? ana_evt : 1'b0;

   // rearm once the signal crosses back past the far threshold
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= is_analog ? armed_d : 1'b0;
      end
   end
endmodule // lts_qual
`default_nettype wire

// ===== tb/lts_top_assertions.sv
`default_nettype none
// ********************
// port checker
// ********************
module lts_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // handshake and status
   input wire logic action_start,
   input wire logic op_pending,
   input wire logic cmd_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // command decode
   wire logic ctl_w = reg_wr && reg_addr == lts_pkg::REG_CTRL;
   wire logic kill_w = ctl_w && (reg_wdata[1] || reg_wdata[2]);
   wire logic init_w = ctl_w && reg_wdata[0] && !kill_w;
   a_reset_quiet: assert property ($rose(rst_n) |-> !op_pending && !action_start && !cmd_error)
      else $error("outputs not clear after reset");
   a_kill_idle: assert property (kill_w |=> !op_pending && !action_start)
      else $error("abort did not reach idle");
   a_init_leave: assert property (init_w && !op_pending |=> op_pending)
      else $error("initiate did not leave idle");
   a_down_steps: assert property ($rose(op_pending) |-> !action_start [*3])
      else $error("action started too early");
   a_start_pulse: assert property (action_start |=> !action_start [*2])
      else $error("start pulse too long");
   a_start_busy: assert property (action_start |-> op_pending && $past(op_pending, 3))
      else $error("start outside a run");
   a_up_steps: assert property ((action_start && !kill_w) ##1 !kill_w [*4] |-> op_pending)
      else $error("left run too soon");
   a_err_set: assert property (ctl_w && reg_wdata[3] && !reg_wdata[0] && !op_pending |-> ##[1:2] cmd_error)
      else $error("override in idle gave no error");
   a_err_hold: assert property (cmd_error && !(ctl_w && (reg_wdata[6] || reg_wdata[2])) |=> cmd_error)
      else $error("error flag dropped");
   a_err_quiet: assert property (!cmd_error && !ctl_w && !$past(ctl_w) && !$past(ctl_w, 2) |=> !cmd_error)
      else $error("error without command");
   a_stat_pend: assert property (reg_rd && reg_addr == lts_pkg::REG_STATUS |=>
      reg_rdata[lts_pkg::STAT_PEND_BIT] == $past(op_pending) && (reg_rdata[2:0] != 3'h0) == $past(op_pending))
      else $error("status disagrees with pending");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
endmodule // lts_chk
bind lts_top lts_chk chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .action_start(action_start), .op_pending(op_pending),
   .cmd_error(cmd_error));
`default_nettype wire

// ===== tb/lts_act_model.sv
`default_nettype none
// ********************
// output hardware model
// ********************
module lts_act_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // answer delay in cycles, at least 1
   input wire logic [7:0] lat,
   // action handshake
   input wire logic action_start,
   output logic action_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q;
   // action runs lat cycles, then one done cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         action_done <= 1'b0;
      end else begin
         action_done <= cnt_q == 8'h01;
         if (action_start) begin
            cnt_q <= lat;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // lts_act_model
`default_nettype wire

// ===== tb/lts_top_bench.sv
`default_nettype none
module lts_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, reg_wr, reg_rd, ext_trig, bus_trig, action_done, action_start, op_pending, cmd_error;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v;
   logic [11:0] ana_int, ana_ext;
   logic [7:0] lat;
   int mismatches, samples_checked, cycles, starts, n, n0;
   logic [15:0] rv_e [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0001, 16'h0800, 16'h0010, 16'h0, 16'h0,
      16'h0};
   // ********************
   // design and output hardware
   // ********************
   lts_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig(ext_trig), .bus_trig(bus_trig), .ana_int(ana_int),
      .ana_ext(ana_ext), .action_done(action_done), .action_start(action_start), .op_pending(op_pending),
      .cmd_error(cmd_error));
   lts_act_model hw_u (.clk(clk), .rst_n(rst_n), .lat(lat), .action_start(action_start), .action_done(action_done));
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // start pulse counter and hang guard
   always @(negedge clk) starts <= starts + int'(action_start === 1'b1);
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   // ********************
   // access tasks
   // ********************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // wait for start (0), done (1) or idle (2)
   task automatic till(input int sel, output int k);
      k = 0;
      while (k < 5000 && (sel == 0 ? action_start : sel == 1 ? action_done : !op_pending) !== 1'b1) begin
         tick();
         k++;
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ********************
   // test sequence
   // ********************
   initial begin
      {rst_n, reg_wr, reg_rd, ext_trig, bus_trig, reg_addr, reg_wdata} = '0;
      {ana_int, ana_ext, lat} = {12'h100, 12'h100, 8'h01};
      {mismatches, samples_checked, cycles, starts} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, read-only status, unmapped place
      wr(lts_pkg::REG_STATUS, 16'hffff);
      wr(4'ha, 16'hffff);
      for (int i = 0; i < 11; i++) begin
         rd(4'(i), v);
         check("reset value", v, rv_e[i]);
      end
      $display("test reset values done");
      // one run, prompt then slow answer
      for (int j = 0; j < 2; j++) begin
         lat <= j ? 8'h14 : 8'h01;
         wr(lts_pkg::REG_CTRL, 16'h0001);
         till(0, n);
         check("start delay", 16'(n), 16'h0003);
         till(1, n);
         check("busy at done", op_pending, 16'h0001);
         till(2, n);
         check("return steps", 16'(n), 16'h0004);
      end
      $display("test single run done");
      // layer counts
      wr(lts_pkg::REG_CNT0, 16'h0002);
      wr(lts_pkg::REG_CNT1, 16'h0003);
      n0 = starts;
      wr(lts_pkg::REG_CTRL, 16'h0001);
      tick();
      till(2, n);
      check("actions per run", 16'(starts - n0), 16'h0006);
      // continuous initiation
      wr(lts_pkg::REG_CONT, 16'h0001);
      till(0, n);
      n0 = 0;
      repeat (200) begin
         tick();
         n0 += int'(op_pending !== 1'b1);
      end
      check("cont stays busy", 16'(n0), 16'h0000);
      wr(lts_pkg::REG_CONT, 16'h0000);
      till(2, n);
      check("cont off idles", 16'(n < 200), 16'h0001);
      // reset command clears settings mid run
      wr(lts_pkg::REG_CONT, 16'h0001);
      wr(lts_pkg::REG_SRC0, 16'(lts_pkg::SRC_BUS));
      wr(lts_pkg::REG_CTRL, 16'h0004);
      tick();
      check("reset cmd idle", op_pending, 16'h0000);
      for (int i = 1; i < 6; i++) begin
         rd(4'(i), v);
         check("after reset cmd", v, rv_e[i]);
      end
      $display("test counts and continuous done");
      // every source except immediate, analog both slopes
      for (int i = 0; i < 6; i++) begin
         if (i == 5) begin
            wr(lts_pkg::REG_SLOPE, 16'h0001);
            ana_int <= 12'h900;
         end
         wr(lts_pkg::REG_SRC0, i == 5 ? 16'(lts_pkg::SRC_ANALOG_INT) : 16'(i + 1));
         n0 = starts;
         wr(lts_pkg::REG_CTRL, 16'h0001);
         if (i == 3) ana_int <= 12'h808;
         repeat (12) tick();
         if (i != 2) check("no early start", 16'(starts - n0), 16'h0000);
         case (i)
            0: bus_trig <= 1'b1;
            1: ext_trig <= 1'b1;
            3: ana_int <= 12'h900;
            4: ana_ext <= 12'h900;
            5: ana_int <= 12'h100;
            default: ;
         endcase
         till(0, n);
         check("source fires", action_start, 16'h0001);
         till(2, n);
         {bus_trig, ext_trig, ana_int, ana_ext} <= {2'b00, 12'h100, 12'h100};
         wr(lts_pkg::REG_SLOPE, 16'h0000);
      end
      $display("test sources done");
      // overrides, status, abort, power-on reset
      wr(lts_pkg::REG_CTRL, 16'h0008);
      rd(lts_pkg::REG_STATUS, v);
      check("error in idle", v, 16'h0020);
      wr(lts_pkg::REG_SRC0, 16'(lts_pkg::SRC_BUS));
      wr(lts_pkg::REG_SRC1, 16'(lts_pkg::SRC_BUS));
      wr(lts_pkg::REG_CTRL, 16'h0001);
      wr(lts_pkg::REG_CTRL, 16'h0010);
      rd(lts_pkg::REG_STATUS, v);
      check("status in layer 0", v & 16'h003f, 16'h0033);
      wr(lts_pkg::REG_CTRL, 16'h0040);
      wr(lts_pkg::REG_CTRL, 16'h0008);
      wr(lts_pkg::REG_CTRL, 16'h0010);
      till(0, n);
      check("override fires", action_start, 16'h0001);
      till(2, n);
      check("no error", cmd_error, 16'h0000);
      wr(lts_pkg::REG_CTRL, 16'h0001);
      wr(lts_pkg::REG_CTRL, 16'h0020);
      rd(lts_pkg::REG_STATUS, v);
      check("bus command", v & 16'h003f, 16'h0012);
      wr(lts_pkg::REG_CTRL, 16'h0002);
      tick();
      check("abort idles", op_pending, 16'h0000);
      wr(lts_pkg::REG_CTRL, 16'h0001);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) tick();
      check("power-on idles", op_pending, 16'h0000);
      $display("test override and abort done");
      final_report();
   end
endmodule // lts_top_bench
`default_nettype wire
